// [design/lws_pkg.sv]
// Shared constants for the late-write pipelined static memory and its
// controller. Assumes nothing beyond a SystemVerilog compiler.
package lws_pkg;
  // ----------------------------------------------------------------------
  // Organisation
  // ----------------------------------------------------------------------
  localparam int LANE_W = 9;           // Bits per byte lane.
  localparam int DEF_LANES = 4;        // 36-bit organisation.
  localparam int DEF_ADDR_W = 19;      // 512K words.
  localparam int NARROW_LANES = 2;     // 18-bit organisation.
  localparam int NARROW_ADDR_W = 20;   // 1M words.
  localparam int DEF_SIM_DEPTH_W = 10; // Words actually held in the model.
  // ----------------------------------------------------------------------
  // Register map of the controller (APB, word aligned)
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;   // Go, write, sleep.
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_BYTE_EN = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14; // Busy, done.
  localparam int CTRL_GO = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_SLEEP = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int READ_LATENCY = 2; // Address edge to data edge.
  localparam int WAKE_CYCLES = 2;  // Edges ignored after sleep falls.
endpackage

// [design/lws_if.sv]
// Synchronous pin interface between the memory and its controller.
// Assumes the bench resolves the data wire from the two enables.
`timescale 1ns/10ps
`default_nettype none
interface lws_if
  import lws_pkg::*;
#(parameter int LANES = DEF_LANES, parameter int ADDR_W = DEF_ADDR_W);
  logic clock_pair_t;
  logic clock_pair_c;
  logic [ADDR_W-1:0] addr;
  logic select_n;
  logic write_enable_n;
  logic [LANES-1:0] byte_write_enable_n;
  logic out_enable_n;
  logic sleep_request;
  logic read_protocol_select_low;
  logic read_protocol_select_high;
  logic [LANES*LANE_W-1:0] dq_mem_o;
  logic dq_mem_oe;
  logic [LANES*LANE_W-1:0] dq_ctl_o;
  logic dq_ctl_oe;
  logic [LANES*LANE_W-1:0] dq_in;
  modport mem (input clock_pair_t, clock_pair_c, addr, select_n,
    write_enable_n, byte_write_enable_n, out_enable_n, sleep_request,
    read_protocol_select_low, read_protocol_select_high, dq_in,
    output dq_mem_o, dq_mem_oe);
  modport ctl (output clock_pair_t, clock_pair_c, addr, select_n,
    write_enable_n, byte_write_enable_n, out_enable_n, sleep_request,
    read_protocol_select_low, read_protocol_select_high, dq_ctl_o,
    dq_ctl_oe, input dq_in);
endinterface
`default_nettype wire

// [design/lws_mem.sv]
// Late-write pipelined static memory with dual-cycle deselect.
// Assumes the clock pair is driven by the controller as pclk and its
// inverse, and that the bench resolves dq_in from both enables.
// How it works
// RULE1: Inputs sampled only on true clock rise.
// RULE2: Write starts at edge, internally timed.
// RULE3: Read data leaves through rising-edge register.
// RULE4: Output turn-off delayed through pipeline.
// RULE5: Controller ties selects low and high.
// RULE6: Sleep or stopped clock keeps contents.
// RULE7: 1Mx18 or 512Kx36 organisation.
// RULE8: Only enabled 9-bit lanes get written.
// RULE9: One active-low write enable per lane.
// RULE10: Write enable low writes, high reads.
// RULE11: Output enable gates drivers asynchronously.
// RULE12: Read after write returns pending data.
// RULE13: Sample on true rise, complement fall.
// RULE14: Read data driven at second edge.
// RULE15: Write data one edge after address.
// RULE16: Deselect acts at following edge.
// RULE17: No lane enabled means write aborted.
// RULE18: Sleep floats outputs, ignores commands.
`timescale 1ns/10ps
`default_nettype none
module lws_mem
  import lws_pkg::*;
#(
  parameter int LANES = DEF_LANES,
  parameter int ADDR_W = DEF_ADDR_W,
  parameter int DEPTH_W = DEF_SIM_DEPTH_W
)(
  input wire logic presetn, // Asynchronous reset, active low.
  lws_if.mem pins           // Synchronous pin side.
);
  localparam int W = LANES * LANE_W;

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // Only the two documented organisations are served. [RULE7]
  if (!((LANES == DEF_LANES && ADDR_W == DEF_ADDR_W) ||
        (LANES == NARROW_LANES && ADDR_W == NARROW_ADDR_W)))
    $error("lws_mem: unsupported organisation");
  if (DEPTH_W < 1 || DEPTH_W > ADDR_W)
    $error("lws_mem: bad model depth");

  // Storage is only as deep as the model needs; contents have no reset,
  // so they survive sleep and a stopped clock. [RULE6]
  logic [W-1:0] mem [0:(1<<DEPTH_W)-1];

  logic clk;
  assign clk = pins.clock_pair_t; // Rise of true equals fall of complement. [RULE13]

  logic wr_pend_ff, nxt_wr_pend;
  logic [ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;
  logic [LANES-1:0] wr_be_ff, nxt_wr_be;
  logic rd_pend_ff, nxt_rd_pend;
  logic [ADDR_W-1:0] rd_addr_ff, nxt_rd_addr;
  logic [W-1:0] q_ff, nxt_q;
  logic q_valid_ff, nxt_q_valid;
  logic [1:0] wake_ff, nxt_wake;
  logic active;
  logic [W-1:0] merged;

  // A command is taken only when awake and the strap pins are legal.
  assign active = !pins.sleep_request && (wake_ff == 2'h0) &&
                  !pins.read_protocol_select_low &&
                  pins.read_protocol_select_high; // [RULE5] [RULE18]

  // ----------------------------------------------------------------------
  // Write merge
  // ----------------------------------------------------------------------
  // Lanes of the pending write overlay the stored word. [RULE8]
  always_comb
  begin
    merged = mem[wr_addr_ff[DEPTH_W-1:0]];
    for (int i = 0; i < LANES; i++)
      if (wr_be_ff[i])
        merged[i*LANE_W +: LANE_W] = pins.dq_in[i*LANE_W +: LANE_W];
  end

  // ----------------------------------------------------------------------
  // Command pipeline
  // ----------------------------------------------------------------------
  // Next-state for the command, write and read pipelines.
  always_comb
  begin
    nxt_wake = wake_ff;
    if (pins.sleep_request)
      nxt_wake = 2'(WAKE_CYCLES); // Hold off after sleep falls. [RULE18]
    else if (wake_ff != 2'h0)
      nxt_wake = wake_ff - 2'h1;
    // Write: address and enables now, data one edge later. [RULE2] [RULE15]
    nxt_wr_pend = active && !pins.select_n && !pins.write_enable_n; // [RULE1] [RULE10]
    nxt_wr_addr = pins.addr;
    nxt_wr_be = ~pins.byte_write_enable_n; // [RULE9] [RULE17]
    nxt_rd_pend = active && !pins.select_n && pins.write_enable_n; // [RULE10]
    nxt_rd_addr = pins.addr;
    // Output register: loaded on the second edge after the address. [RULE3] [RULE14]
    nxt_q = q_ff;
    if (rd_pend_ff)
    begin
      // Coherence: a write whose data arrives now wins. [RULE12]
      if (wr_pend_ff && wr_addr_ff == rd_addr_ff)
        nxt_q = merged;
      else
        nxt_q = mem[rd_addr_ff[DEPTH_W-1:0]];
    end
    // Deselect or write turns drivers off one edge later; sleep clears the register at the same edge. [RULE4] [RULE16]
    nxt_q_valid = rd_pend_ff && !pins.sleep_request;
  end

  // Registers; the array write is the self-timed write. [RULE2]
  always_ff @(posedge clk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
      wr_be_ff <= '0;
      rd_pend_ff <= 1'b0;
      rd_addr_ff <= '0;
      q_ff <= '0;
      q_valid_ff <= 1'b0;
      wake_ff <= 2'h0;
    end
    else
    begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      wr_be_ff <= nxt_wr_be;
      rd_pend_ff <= nxt_rd_pend;
      rd_addr_ff <= nxt_rd_addr;
      q_ff <= nxt_q;
      q_valid_ff <= nxt_q_valid;
      wake_ff <= nxt_wake;
    end
  end

  // Array update, with no reset so data is never lost. [RULE8] [RULE17]
  always_ff @(posedge clk)
  begin
    if (wr_pend_ff && (wr_be_ff != '0))
      mem[wr_addr_ff[DEPTH_W-1:0]] <= merged;
  end

  // ----------------------------------------------------------------------
  // Output drivers
  // ----------------------------------------------------------------------
  // Output enable and sleep act at once, with no clock. [RULE11] [RULE18]
  assign pins.dq_mem_o = q_ff;
  assign pins.dq_mem_oe = q_valid_ff && !pins.out_enable_n &&
                          !pins.sleep_request;
endmodule
`default_nettype wire

// [design/lws_ctl.sv]
// APB-programmed controller that drives the memory's synchronous port.
// Assumes the memory sits on the other side of lws_if.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module lws_ctl
  import lws_pkg::*;
#(
  parameter int LANES = DEF_LANES,
  parameter int ADDR_W = DEF_ADDR_W
)(
  input wire logic pclk,           // System clock, 250 MHz.
  input wire logic presetn,        // Asynchronous reset, active low.
  input wire logic psel,           // APB select.
  input wire logic penable,        // APB access phase.
  input wire logic pwrite,         // APB direction.
  input wire logic [7:0] paddr,    // APB byte address.
  input wire logic [31:0] pwdata,  // APB write data.
  output logic [31:0] prdata,      // APB read data.
  output logic pready,             // APB ready, always high.
  output logic pslverr,            // APB error on unmapped address.
  lws_if.ctl pins                  // Memory pin side.
);
  localparam int W = LANES * LANE_W;
  if (W > 36 || LANES < 1)
    $error("lws_ctl: unsupported width");

  typedef enum logic [3:0] {
    S_IDLE = 4'h1, S_CMD = 4'h2, S_WAIT = 4'h4, S_DONE = 4'h8
  } lws_st_t;

  lws_st_t st_ff, nxt_st;
  logic [1:0] cnt_ff, nxt_cnt;
  logic wr_ff, nxt_wr;
  logic sleep_ff, nxt_sleep;
  logic done_ff, nxt_done;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [35:0] wdata_ff, nxt_wdata;
  logic [LANES-1:0] be_ff, nxt_be;
  logic [35:0] rdata_ff, nxt_rdata;
  logic [31:0] rd_mux;
  logic hit, go, wr_acc;

  function automatic logic known(input logic [7:0] a);
    known = a == REG_CTRL || a == REG_ADDR || a == REG_WDATA ||
            a == REG_BYTE_EN || a == REG_RDATA || a == REG_STATUS;
  endfunction

  // ----------------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped words
  // ----------------------------------------------------------------------
  assign hit = known(paddr);
  assign wr_acc = psel && penable && pwrite && hit;
  assign go = wr_acc && paddr == REG_CTRL && pwdata[CTRL_GO] &&
              st_ff == S_IDLE;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Read mux; the upper bits of the wide data word are not visible.
  always_comb
  begin
    rd_mux = 32'h0;
    unique case (paddr)
      REG_CTRL: rd_mux = {29'h0, sleep_ff, wr_ff, 1'b0};
      REG_ADDR: rd_mux = 32'(addr_ff);
      REG_WDATA: rd_mux = wdata_ff[31:0];
      REG_BYTE_EN: rd_mux = 32'(be_ff);
      REG_RDATA: rd_mux = rdata_ff[31:0];
      REG_STATUS: rd_mux = {30'h0, done_ff, st_ff != S_IDLE};
      default: rd_mux = 32'h0;
    endcase
  end
  assign prdata = (psel && !pwrite) ? rd_mux : 32'h0;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // One command per go: address edge, then data edge(s).
  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_wr = wr_ff;
    nxt_sleep = sleep_ff;
    nxt_done = done_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_be = be_ff;
    nxt_rdata = rdata_ff;
    if (wr_acc && paddr == REG_ADDR) nxt_addr = pwdata[ADDR_W-1:0];
    if (wr_acc && paddr == REG_WDATA) nxt_wdata = {4'h0, pwdata};
    if (wr_acc && paddr == REG_BYTE_EN) nxt_be = pwdata[LANES-1:0];
    if (wr_acc && paddr == REG_CTRL)
    begin
      nxt_sleep = pwdata[CTRL_SLEEP];
      if (st_ff == S_IDLE) nxt_wr = pwdata[CTRL_WRITE];
    end
    if (go) nxt_done = 1'b0;
    unique case (st_ff)
      S_IDLE: if (go && !pwdata[CTRL_SLEEP]) nxt_st = S_CMD;
      S_CMD:
      begin
        nxt_st = S_WAIT;
        nxt_cnt = 2'(READ_LATENCY);
      end
      S_WAIT:
      begin
        nxt_cnt = cnt_ff - 2'h1;
        // Read data stands for one cycle only, after the second edge, so
        // it is taken at the edge that closes that cycle. [RULE14]
        if (!wr_ff && cnt_ff == 2'h1) nxt_rdata = 36'(pins.dq_in);
        if (cnt_ff == 2'h1 || wr_ff)
          nxt_st = S_DONE;
      end
      S_DONE:
      begin
        nxt_done = 1'b1;
        nxt_st = S_IDLE;
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= S_IDLE;
      cnt_ff <= 2'h0;
      wr_ff <= 1'b0;
      sleep_ff <= 1'b0;
      done_ff <= 1'b0;
      addr_ff <= '0;
      wdata_ff <= 36'h0;
      be_ff <= '0;
      rdata_ff <= 36'h0;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      wr_ff <= nxt_wr;
      sleep_ff <= nxt_sleep;
      done_ff <= nxt_done;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      be_ff <= nxt_be;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  // Commands change right after a rising edge, so they are stable around
  // the next one; strap pins never move. [RULE1] [RULE5] [RULE13]
  assign pins.clock_pair_t = pclk;
  assign pins.clock_pair_c = ~pclk;
  assign pins.read_protocol_select_low = 1'b0;
  assign pins.read_protocol_select_high = 1'b1;
  assign pins.sleep_request = sleep_ff;
  assign pins.addr = addr_ff;
  assign pins.select_n = !(st_ff == S_CMD);
  assign pins.write_enable_n = !wr_ff; // [RULE10]
  assign pins.byte_write_enable_n = ~be_ff; // [RULE9]
  assign pins.out_enable_n = wr_ff; // Keep drivers quiet during writes.
  // Data follows the address edge by one edge. [RULE15]
  assign pins.dq_ctl_o = wdata_ff[W-1:0];
  assign pins.dq_ctl_oe = wr_ff && st_ff == S_WAIT;
endmodule
`default_nettype wire

// [verif/lws_props.sv]
// Checker for the pin interface between the memory and its controller.
// Assumes the bench instantiates it beside the interface instance.
`timescale 1ns/10ps
`default_nettype none
module lws_props (
  input wire logic presetn, // Reset, active low.
  input wire logic clock_pair_t, // True clock.
  input wire logic clock_pair_c, // Complement clock.
  input wire logic select_n, // Select, active low.
  input wire logic write_enable_n, // Write enable, active low.
  input wire logic out_enable_n, // Output enable, active low.
  input wire logic sleep_request, // Sleep.
  input wire logic read_protocol_select_low, // Strap, low.
  input wire logic read_protocol_select_high, // Strap, high.
  input wire logic dq_mem_oe, // Memory drives the data wire.
  input wire logic dq_ctl_oe // Controller drives the data wire.
);
  // --------------------------------------------------------------------
  // Pin relations
  // --------------------------------------------------------------------
  // All relations are judged at the true clock rise.
  default clocking cb @(posedge clock_pair_t);
  endclocking
  default disable iff (!presetn);

  property p_straps;
    !read_protocol_select_low && read_protocol_select_high;
  endproperty
  a_straps: assert property (p_straps)
    else $error("protocol straps at wrong levels");

  property p_clk_pair;
    clock_pair_c != clock_pair_t;
  endproperty
  a_clk_pair: assert property (p_clk_pair)
    else $error("clock pair not complementary");

  // The wake window after sleep is skipped, since commands are ignored.
  property p_read_lat;
    (!select_n && write_enable_n && !sleep_request &&
      !$past(sleep_request, 1) && !$past(sleep_request, 2) &&
      !$past(sleep_request, 3))
      |-> ##2 (dq_mem_oe || out_enable_n || sleep_request);
  endproperty
  a_read_lat: assert property (p_read_lat)
    else $error("read data not driven at second edge");

  property p_oe_gate;
    (out_enable_n || sleep_request) |-> !dq_mem_oe;
  endproperty
  a_oe_gate: assert property (p_oe_gate)
    else $error("memory drives while disabled");

  property p_dcd;
    $past(select_n, 2) |-> !dq_mem_oe;
  endproperty
  a_dcd: assert property (p_dcd)
    else $error("memory drives after deselect");

  property p_write_quiet;
    (!select_n && !write_enable_n) |-> ##2 !dq_mem_oe;
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("memory drives after a write command");

  property p_late_write;
    (!select_n && !write_enable_n) |=> dq_ctl_oe;
  endproperty
  a_late_write: assert property (p_late_write)
    else $error("write data not presented one edge late");

  property p_ctl_cause;
    $rose(dq_ctl_oe) |-> (!$past(select_n) && !$past(write_enable_n));
  endproperty
  a_ctl_cause: assert property (p_ctl_cause)
    else $error("controller drives without a write");

  property p_no_fight;
    !(dq_mem_oe && dq_ctl_oe);
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive the data wire");
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench joining controller and memory through lws_if.
// Assumes the design package and both ends are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import lws_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [35:0] shadow;
  int errors = 0;
  int n_compared = 0;
  // --------------------------------------------------------------------
  // Design and wire resolution
  // --------------------------------------------------------------------
  // A released wire floats, so a stale value can never pass as data.
  lws_if pins();
  assign pins.dq_in = pins.dq_mem_oe ? pins.dq_mem_o :
    pins.dq_ctl_oe ? pins.dq_ctl_o : 'z;
  lws_ctl lws_ctl_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins));
  lws_mem #(.DEPTH_W(6)) lws_mem_i (
    .presetn(presetn), .pins(pins));
  lws_props lws_props_i (.presetn(presetn),
    .clock_pair_t(pins.clock_pair_t), .clock_pair_c(pins.clock_pair_c),
    .select_n(pins.select_n), .write_enable_n(pins.write_enable_n),
    .out_enable_n(pins.out_enable_n), .sleep_request(pins.sleep_request),
    .read_protocol_select_low(pins.read_protocol_select_low),
    .read_protocol_select_high(pins.read_protocol_select_high),
    .dq_mem_oe(pins.dq_mem_oe), .dq_ctl_oe(pins.dq_ctl_oe));

  // Clock at 250 MHz.
  always #2 pclk = ~pclk;
  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [35:0] exp,
    input logic [35:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      errors++;
      close_out();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    check("pslverr", 36'h0, {35'h0, e});
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  // Runs one memory command and returns the read register afterwards.
  task automatic mem_op(input logic w, input logic [18:0] a,
    input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
    int n;
    logic [31:0] s;
    wr(REG_ADDR, {13'h0, a});
    wr(REG_WDATA, d);
    wr(REG_BYTE_EN, {28'h0, be});
    wr(REG_CTRL, {30'h0, w, 1'b1});
    n = 0;
    do
    begin
      rdr(REG_STATUS, s);
      n++;
    end
    while (s[ST_DONE] !== 1'b1 && n < 50);
    check("done", 36'h1, {35'h0, s[ST_DONE]});
    // A command that never completes ends the run here.
    if (s[ST_DONE] !== 1'b1)
      close_out();
    rdr(REG_RDATA, q);
  endtask
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_write_read;
    logic [31:0] q;
    logic e;
    apb(1'b0, 8'h20, 32'h0, q, e);
    check("unmapped err", 36'h1, {35'h0, e});
    mem_op(1'b1, 19'h5, 32'h1234_5678, 4'hf, q);
    mem_op(1'b1, 19'h6, 32'hcafe_0bad, 4'hf, q);
    mem_op(1'b0, 19'h5, 32'h0, 4'h0, q);
    check("rdata 5", 36'h1234_5678, {4'h0, q});
    mem_op(1'b0, 19'h6, 32'h0, 4'h0, q);
    check("rdata 6", 36'hcafe_0bad, {4'h0, q});
    shadow = 36'h1234_5678;
    $display("test write_read done");
  endtask

  // Each lane alone, then a write with no lane enabled.
  task automatic t_lanes;
    logic [31:0] q;
    logic [35:0] dw;
    for (int i = 0; i < 4; i++)
    begin
      dw = {4'h0, 32'h9abc_def0 ^ (32'h1111_1111 << i)};
      shadow[9*i +: 9] = dw[9*i +: 9];
      mem_op(1'b1, 19'h5, dw[31:0], 4'h1 << i, q);
      mem_op(1'b0, 19'h5, 32'h0, 4'h0, q);
      check("lane read", {4'h0, shadow[31:0]}, {4'h0, q});
    end
    mem_op(1'b1, 19'h5, 32'h0, 4'h0, q);
    mem_op(1'b0, 19'h5, 32'h0, 4'h0, q);
    check("abort read", {4'h0, shadow[31:0]}, {4'h0, q});
    $display("test lanes done");
  endtask

  task automatic t_sleep;
    logic [31:0] q;
    wr(REG_CTRL, 32'h1 << CTRL_SLEEP);
    repeat (20) @(posedge pclk);
    check("sleep pin", 36'h1, {35'h0, pins.sleep_request});
    check("sleep drive", 36'h0, {35'h0, pins.dq_mem_oe});
    wr(REG_CTRL, 32'h0);
    repeat (WAKE_CYCLES + 2) @(posedge pclk);
    mem_op(1'b0, 19'h5, 32'h0, 4'h0, q);
    check("kept data", {4'h0, shadow[31:0]}, {4'h0, q});
    $display("test sleep done");
  endtask
  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_write_read();
    t_lanes();
    t_sleep();
    close_out();
  end
endmodule
`default_nettype wire
